/* File: hdl/conv_pkg.sv */
// Purpose: shared constants and types of the converter configuration block
// Assumes: register port of the processor special-function space, page 0
// Notes:   the local oscillator divide count derives from the mclk rate
package conv_pkg;

    // ********************************
    // register map
    // ********************************
    localparam logic [3:0] REG_PAGE      = 4'h0;
    localparam logic [7:0] ADDR_CONFIG   = 8'h96;
    localparam logic [7:0] ADDR_CONTROL  = 8'h97;
    localparam logic [7:0] CONTROL_RESET = 8'h21;
    localparam logic [7:0] CONFIG_RESET  = 8'h00;
    localparam logic [7:0] CONFIG_WMASK  = 8'h7f;

    // ********************************
    // field layouts
    // ********************************
    typedef struct packed {
        logic [1:0] min_pulse_width;
        logic       switch_size_select;
        logic       reserved;
        logic       adc_sync;
        logic [2:0] target_voltage_code;
    } control_t;

    typedef struct packed {
        logic       reserved;
        logic [1:0] converter_clock_divider;
        logic       adc_sar_clock_invert;
        logic       converter_clock_invert;
        logic       peak_current_level;
        logic       sleep_rail_float;
        logic       converter_clock_source;
    } config_t;

    // ********************************
    // encodings
    // ********************************
    localparam logic SRC_LOCAL  = 1'b0;
    localparam logic SRC_SYSTEM = 1'b1;
    localparam logic [6:0] MIN_PULSE_NS_0 = 7'd0;
    localparam logic [6:0] MIN_PULSE_NS_1 = 7'd20;
    localparam logic [6:0] MIN_PULSE_NS_2 = 7'd40;
    localparam logic [6:0] MIN_PULSE_NS_3 = 7'd80;
    localparam logic [11:0] MV_000 = 12'd1800;
    localparam logic [11:0] MV_001 = 12'd1900;
    localparam logic [11:0] MV_010 = 12'd2000;
    localparam logic [11:0] MV_011 = 12'd2100;
    localparam logic [11:0] MV_100 = 12'd2400;
    localparam logic [11:0] MV_101 = 12'd2700;
    localparam logic [11:0] MV_110 = 12'd3000;
    localparam logic [11:0] MV_111 = 12'd3300;

    // ********************************
    // timing
    // ********************************
    localparam int MCLK_KHZ      = 10000;
    localparam int LOCAL_OSC_KHZ = 2400;
    localparam int LOCAL_OSC_DIV = MCLK_KHZ / LOCAL_OSC_KHZ;
    localparam int SWITCH_TICKS  = 8;
    localparam int QUIET_START   = 4;

endpackage : conv_pkg

/* File: hdl/rate_div.sv */
// Purpose: one-cycle enable pulse every DIV mclk cycles
// Assumes: single mclk domain, synchronous active-high reset
// Notes:   stands in for the free-running local converter oscillator
`timescale 1ns/1ps
module rate_div #(
    parameter int DIV = 4
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // enable output
    output logic      tick
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    initial begin
        if (DIV < 1) $error("rate_div: DIV must be at least 1");
    end

    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    always_comb begin
        nxt_cnt = (cnt_ff == LAST) ? '0 : cnt_ff + W'(1);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign tick = (cnt_ff == LAST);

    // ********************************
    // period check helper
    // ********************************
    // own count of cycles since the last pulse, kept apart from cnt_ff
    logic [W-1:0] gap_ff;
    logic [W-1:0] nxt_gap;
    logic         seen_ff;
    logic         nxt_seen;

    always_comb begin
        nxt_gap  = tick ? '0 : gap_ff + W'(1);
        nxt_seen = seen_ff | tick;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            gap_ff  <= '0;
            seen_ff <= 1'b0;
        end else begin
            gap_ff  <= nxt_gap;
            seen_ff <= nxt_seen;
        end
    end

    // pulses exactly DIV cycles apart, never early and never late
    tick_period_a: assert property (@(posedge mclk) disable iff (rst)
        seen_ff |-> tick == (gap_ff == LAST))
        else $error("local oscillator tick period wrong");

endmodule : rate_div

/* File: hdl/adc_sync_gen.sv */
// Purpose: align adc tracking and sar clock to the switching cycle
// Assumes: conv_tick is a one-cycle enable per converter clock
// Notes:   quiet interval is the head of each switching cycle, phases below QUIET
`timescale 1ns/1ps
module adc_sync_gen
    import conv_pkg::*;
#(
    parameter int CYCLE = SWITCH_TICKS,
    parameter int QUIET = QUIET_START
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // converter timing and settings
    input  wire logic conv_tick,
    input  wire logic sync_en,
    input  wire logic sar_invert,
    // adc side
    output logic      adc_track_en,
    output logic      adc_sar_clk,
    output logic      adc_sar_tick
);
    localparam int W = $clog2(CYCLE);

    initial begin
        if (CYCLE < 2 || QUIET >= CYCLE || QUIET < 1)
            $error("adc_sync_gen: bad CYCLE or QUIET");
    end

    logic [W-1:0] phase_ff, nxt_phase;
    logic         sar_ff, nxt_sar;
    logic         track_ff, nxt_track;

    always_comb begin
        nxt_phase = phase_ff;
        nxt_sar   = 1'b0;
        nxt_track = 1'b0;
        if (sync_en) begin
            if (conv_tick) begin
                nxt_phase = (phase_ff == W'(CYCLE - 1)) ? '0
                                                        : phase_ff + W'(1);
            end
            nxt_track = (nxt_phase >= W'(QUIET));
            nxt_sar   = conv_tick ? ~sar_ff : sar_ff;
        end else begin
            nxt_phase = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            phase_ff <= '0;
            sar_ff   <= 1'b0;
            track_ff <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
            sar_ff   <= nxt_sar;
            track_ff <= nxt_track;
        end
    end

    // polarity bit only counts while synchronised
    assign adc_sar_clk  = sync_en & (sar_ff ^ sar_invert);
    assign adc_sar_tick = sync_en & conv_tick;
    assign adc_track_en = track_ff;

    no_sync_quiet_a: assert property (@(posedge mclk) disable iff (rst)
        !sync_en ##1 !sync_en |-> !adc_track_en && !adc_sar_clk)
        else $error("adc alignment active without sync");

    // sar state starts low, so the first synced cycle shows the polarity
    sar_invert_a: assert property (@(posedge mclk) disable iff (rst)
        sync_en && !$past(sync_en) |-> adc_sar_clk == sar_invert)
        else $error("sar clock polarity wrong");

    sar_step_a: assert property (@(posedge mclk) disable iff (rst)
        sync_en && $past(sync_en) && $stable(sar_invert)
        |-> $changed(adc_sar_clk) == $past(conv_tick))
        else $error("sar clock out of step with converter");

endmodule : adc_sync_gen

/* File: hdl/conv_regs.sv */
// Purpose: converter control/configuration registers and clock path
// Assumes: one mclk domain; strap pin is asynchronous and synchronised here
// Notes:   converter clock is a one-cycle enable pulse, never a gated clock
`timescale 1ns/1ps
module conv_regs
    import conv_pkg::*;
#(
    parameter int OSC_DIV = LOCAL_OSC_DIV
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // special-function register port
    input  wire logic [3:0]  sfr_page,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    output logic             sfr_hit,
    // power mode
    input  wire logic        cell_strap_pin,
    input  wire logic        sleep_mode,
    // power stage controls
    output logic             converter_enable,
    output logic             rail_to_battery,
    output logic      [1:0]  min_pulse_width,
    output logic      [6:0]  min_pulse_ns,
    output logic             switch_size_select,
    output logic      [2:0]  target_voltage_code,
    output logic      [11:0] target_mv,
    output logic             peak_current_level,
    // converter clock
    output logic             conv_tick,
    output logic             conv_clk_inverted,
    // adc alignment
    output logic             adc_track_en,
    output logic             adc_sar_clk,
    output logic             adc_sar_tick
);

    initial begin
        if (OSC_DIV < 2) $error("conv_regs: OSC_DIV must be at least 2");
    end

    // ********************************
    // strap capture and power mode
    // ********************************
    logic strap_s1_ff, strap_s2_ff;
    logic one_cell_ff, nxt_one_cell;
    logic strap_done_ff, nxt_strap_done;

    // no reset: the pin must be settled here when reset lifts
    always_ff @(posedge mclk) begin
        strap_s1_ff <= cell_strap_pin;
        strap_s2_ff <= strap_s1_ff;
    end

    // mode is latched once after reset release; converter off until then
    always_comb begin
        nxt_one_cell   = one_cell_ff;
        nxt_strap_done = 1'b1;
        if (!strap_done_ff) begin
            nxt_one_cell = strap_s2_ff;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            one_cell_ff   <= 1'b0;
            strap_done_ff <= 1'b0;
        end else begin
            one_cell_ff   <= nxt_one_cell;
            strap_done_ff <= nxt_strap_done;
        end
    end

    // ********************************
    // registers
    // ********************************
    control_t ctl_ff, nxt_ctl;
    config_t  cfg_ff, nxt_cfg;
    logic     page_ok;
    logic     hit_ctl, hit_cfg;

    assign page_ok = (sfr_page == REG_PAGE);
    assign hit_ctl = page_ok && (sfr_addr == ADDR_CONTROL);
    assign hit_cfg = page_ok && (sfr_addr == ADDR_CONFIG);

    always_comb begin
        nxt_ctl = ctl_ff;
        nxt_cfg = cfg_ff;
        if (sfr_wr && hit_ctl) begin
            nxt_ctl = control_t'(sfr_wdata);
        end
        if (sfr_wr && hit_cfg) begin
            nxt_cfg = config_t'(sfr_wdata & CONFIG_WMASK);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctl_ff <= control_t'(CONTROL_RESET);
            cfg_ff <= config_t'(CONFIG_RESET);
        end else begin
            ctl_ff <= nxt_ctl;
            cfg_ff <= nxt_cfg;
        end
    end

    // ********************************
    // read path
    // ********************************
    logic [7:0] rdata_ff, nxt_rdata;
    logic       hit_ff, nxt_hit;

    always_comb begin
        nxt_rdata = 8'h00;
        nxt_hit   = 1'b0;
        if (sfr_rd) begin
            nxt_hit = hit_ctl | hit_cfg;
            if (hit_ctl) begin
                nxt_rdata = ctl_ff;
            end else if (hit_cfg) begin
                nxt_rdata = cfg_ff & CONFIG_WMASK;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_ff <= 8'h00;
            hit_ff   <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            hit_ff   <= nxt_hit;
        end
    end

    assign sfr_rdata = rdata_ff;
    assign sfr_hit   = hit_ff;

    // ********************************
    // power stage controls
    // ********************************
    logic [6:0]  mpw_ns;
    logic [11:0] mv;

    always_comb begin
        unique case (ctl_ff.min_pulse_width)
            2'b00: mpw_ns = MIN_PULSE_NS_0;
            2'b01: mpw_ns = MIN_PULSE_NS_1;
            2'b10: mpw_ns = MIN_PULSE_NS_2;
            2'b11: mpw_ns = MIN_PULSE_NS_3;
        endcase
        unique case (ctl_ff.target_voltage_code)
            3'b000: mv = MV_000;
            3'b001: mv = MV_001;
            3'b010: mv = MV_010;
            3'b011: mv = MV_011;
            3'b100: mv = MV_100;
            3'b101: mv = MV_101;
            3'b110: mv = MV_110;
            3'b111: mv = MV_111;
        endcase
    end

    assign min_pulse_width     = ctl_ff.min_pulse_width;
    assign min_pulse_ns        = mpw_ns;
    assign switch_size_select  = ctl_ff.switch_size_select;
    assign target_voltage_code = ctl_ff.target_voltage_code;
    assign target_mv           = mv;
    assign peak_current_level  = cfg_ff.peak_current_level;
    assign converter_enable    = one_cell_ff & ~sleep_mode;
    assign rail_to_battery     = one_cell_ff & sleep_mode
                               & ~cfg_ff.sleep_rail_float;

    // ********************************
    // converter clock path
    // ********************************
    logic       osc_tick;
    logic       src_ff, nxt_src;
    logic [1:0] div_ff, nxt_div;
    logic       inv_ff, nxt_inv;
    logic [2:0] cnt_ff, nxt_cnt;
    logic [2:0] last_cnt, half_cnt;
    logic       sys_tick, tick;

    rate_div #(.DIV(OSC_DIV)) u_osc (
        .mclk (mclk),
        .rst  (rst),
        .tick (osc_tick)
    );

    always_comb begin
        unique case (div_ff)
            2'b00: last_cnt = 3'd0;
            2'b01: last_cnt = 3'd1;
            2'b10: last_cnt = 3'd3;
            2'b11: last_cnt = 3'd7;
        endcase
        half_cnt = 3'((4'(last_cnt) + 4'd1) >> 1);
    end

    // inversion moves the system edge by half a divided period at divide by 2, 4 or 8
    assign sys_tick = (cnt_ff == (inv_ff ? (half_cnt == 3'd0 ? 3'd0
                                                             : half_cnt - 3'd1)
                                         : last_cnt));
    assign tick = (src_ff == SRC_SYSTEM) ? sys_tick : osc_tick;

    // new settings only take effect on an edge of the running clock
    always_comb begin
        nxt_src = src_ff;
        nxt_div = div_ff;
        nxt_inv = inv_ff;
        nxt_cnt = (cnt_ff == last_cnt) ? 3'd0 : cnt_ff + 3'd1;
        if (tick) begin
            nxt_src = cfg_ff.converter_clock_source;
            nxt_div = cfg_ff.converter_clock_divider;
            nxt_inv = cfg_ff.converter_clock_invert;
            if (nxt_div != div_ff || nxt_inv != inv_ff ||
                nxt_src != src_ff) begin
                nxt_cnt = 3'd0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            src_ff <= SRC_LOCAL;
            div_ff <= 2'b00;
            inv_ff <= 1'b0;
            cnt_ff <= 3'd0;
        end else begin
            src_ff <= nxt_src;
            div_ff <= nxt_div;
            inv_ff <= nxt_inv;
            cnt_ff <= nxt_cnt;
        end
    end

    assign conv_tick         = tick;
    assign conv_clk_inverted = (src_ff == SRC_SYSTEM) & inv_ff;

    // ********************************
    // adc alignment
    // ********************************
    // software must clear the adc sample divider first
    adc_sync_gen u_adc_sync (
        .mclk         (mclk),
        .rst          (rst),
        .conv_tick    (tick),
        .sync_en      (ctl_ff.adc_sync),
        .sar_invert   (cfg_ff.adc_sar_clock_invert),
        .adc_track_en (adc_track_en),
        .adc_sar_clk  (adc_sar_clk),
        .adc_sar_tick (adc_sar_tick)
    );

    // ********************************
    // checks
    // ********************************
    sequence cfg_write_s;
        sfr_wr && hit_cfg;
    endsequence

    sequence cfg_read_s;
        sfr_rd && hit_cfg;
    endsequence

    reset_value_a: assert property (@(posedge mclk)
        $fell(rst) |-> ctl_ff == CONTROL_RESET && cfg_ff == CONFIG_RESET)
        else $error("registers not at reset value");

    top_bit_zero_a: assert property (@(posedge mclk) disable iff (rst)
        cfg_write_s ##1 cfg_read_s |=> sfr_hit && !sfr_rdata[7])
        else $error("config top bit reads one");

    ctl_readback_a: assert property (@(posedge mclk) disable iff (rst)
        sfr_wr && hit_ctl ##1 sfr_rd && hit_ctl && !sfr_wr
        |=> sfr_rdata == $past(sfr_wdata, 2))
        else $error("control readback mismatch");

    unmapped_a: assert property (@(posedge mclk) disable iff (rst)
        sfr_rd && !(hit_ctl || hit_cfg) |=> !sfr_hit && sfr_rdata == 8'h00)
        else $error("unmapped read answered");

    voltage_map_a: assert property (@(posedge mclk) disable iff (rst)
        target_voltage_code == 3'b101 |-> target_mv == 12'd2700)
        else $error("voltage code 101 mapped wrong");

    pulse_map_a: assert property (@(posedge mclk) disable iff (rst)
        min_pulse_width == 2'b11 |-> min_pulse_ns == 7'd80)
        else $error("min pulse code 11 mapped wrong");

    two_cell_off_a: assert property (@(posedge mclk) disable iff (rst)
        strap_done_ff && !one_cell_ff |-> !converter_enable
                                           && !rail_to_battery)
        else $error("converter on in two-cell mode");

    sleep_rail_a: assert property (@(posedge mclk) disable iff (rst)
        one_cell_ff && sleep_mode |-> !converter_enable &&
        rail_to_battery == !cfg_ff.sleep_rail_float)
        else $error("sleep rail connection wrong");

    div8_period_a: assert property (@(posedge mclk) disable iff (rst)
        tick && src_ff == SRC_SYSTEM && div_ff == 2'b11 && !inv_ff
        && cfg_ff.converter_clock_source && cfg_ff[6:3] == 4'b1100
        |=> !tick [* 7] ##1 tick)
        else $error("divide by 8 period wrong");

    settings_at_edge_a: assert property (@(posedge mclk) disable iff (rst)
        !$past(tick) |-> $stable(div_ff) && $stable(src_ff))
        else $error("clock settings changed off edge");

endmodule : conv_regs

/* File: testbench/stage_meter.sv */
// Purpose: far-side meter of converter tick period and adc activity
// Assumes: mclk domain, conv_tick is a one-cycle enable
// Notes:   behavioural observer only; it drives nothing back
`timescale 1ns/1ps
module stage_meter (
    // clock and clear
    input  wire logic       mclk,
    input  wire logic       clr,
    // block outputs
    input  wire logic       conv_tick,
    input  wire logic       adc_track_en,
    input  wire logic       adc_sar_clk,
    // measurements
    output logic      [7:0] period,
    output logic            track_seen,
    output logic            sar_seen
);
    logic [7:0] cnt;

    // ********************************
    // measurement
    // ********************************
    // first period after clr may be partial; callers settle first
    always @(posedge mclk) begin
        if (clr) begin
            cnt <= 8'h00;
            period <= 8'h00;
            track_seen <= 1'b0;
            sar_seen <= 1'b0;
        end else begin
            cnt <= conv_tick ? 8'h00 : cnt + 8'h01;
            if (conv_tick) begin
                period <= cnt + 8'h01;
            end
            if (adc_track_en) begin
                track_seen <= 1'b1;
            end
            if (adc_sar_clk) begin
                sar_seen <= 1'b1;
            end
        end
    end
endmodule : stage_meter

/* File: testbench/conv_regs_tb.sv */
// Purpose: self-checking bench of the converter register block
// Assumes: 10 MHz mclk, synchronous active-high rst
// Notes:   OSC_DIV left at its default of 4
`timescale 1ns/1ps
module conv_regs_tb;
    import conv_pkg::*;
    logic        mclk = 1'b0, rst = 1'b1, clr = 1'b0;
    logic [3:0]  page = 4'h0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
    logic        wr = 1'b0, rd = 1'b0, hit, strap = 1'b1, sleep = 1'b0;
    logic        en, rail, sw, tick, inv, trk, sar, stk;
    logic [1:0]  mpw;
    logic [6:0]  mns;
    logic [2:0]  vc;
    logic [11:0] mv;
    logic [7:0]  per, rv;
    logic        tseen, sseen, pk;
    int          bad_count = 0, cmp_count = 0, cyc = 0;
    logic [11:0] mv_tab [8] = '{12'h708, 12'h76c, 12'h7d0, 12'h834,
                                12'h960, 12'ha8c, 12'hbb8, 12'hce4};
    logic [6:0]  ns_tab [4] = '{7'h00, 7'h14, 7'h28, 7'h50};

    always #50 mclk = ~mclk;

    conv_regs dut (.mclk(mclk), .rst(rst), .sfr_page(page),
        .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata),
        .sfr_rdata(rdata), .sfr_hit(hit), .cell_strap_pin(strap),
        .sleep_mode(sleep), .converter_enable(en),
        .rail_to_battery(rail), .min_pulse_width(mpw),
        .min_pulse_ns(mns), .switch_size_select(sw),
        .target_voltage_code(vc), .target_mv(mv),
        .peak_current_level(pk), .conv_tick(tick),
        .conv_clk_inverted(inv), .adc_track_en(trk),
        .adc_sar_clk(sar), .adc_sar_tick(stk));

    stage_meter meter (.mclk(mclk), .clr(clr), .conv_tick(tick),
        .adc_track_en(trk), .adc_sar_clk(sar), .period(per),
        .track_seen(tseen), .sar_seen(sseen));

    // ********************************
    // shared tasks
    // ********************************
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : check

    task automatic tk(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tk

    task automatic wr_reg(input logic [3:0] p, input logic [7:0] a,
                          input logic [7:0] d);
        @(posedge mclk);
        page <= p;
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic h);
        @(posedge mclk);
        page <= 4'h0;
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        d = rdata;
        h = hit;
    endtask : rd_reg

    // write, then read the same register on the very next edge
    task automatic wr_rd_reg(input logic [7:0] a, input logic [7:0] d,
                             output logic [7:0] q, output logic h);
        @(posedge mclk);
        page <= 4'h0;
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        q = rdata;
        h = hit;
    endtask : wr_rd_reg

    task automatic settle();
        repeat (20) @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        tk(40);
    endtask : settle

    task automatic do_reset();
        @(posedge mclk);
        rst <= 1'b1;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
    endtask : do_reset

    // ********************************
    // scenarios
    // ********************************
    task automatic t_reset();
        logic h;
        rd_reg(ADDR_CONTROL, rv, h);
        check(rv, 8'h21);
        check(h, 1'b1);
        rd_reg(ADDR_CONFIG, rv, h);
        check(rv, 8'h00);
        check({mv, sw, mns}, {12'h76c, 1'b1, 7'h00});
        check({en, inv}, 2'b10);
        settle();
        check(per, 8'h04);
        $display("test reset done");
    endtask : t_reset

    task automatic t_control();
        logic h;
        for (int i = 0; i < 8; i++) begin
            wr_reg(4'h0, ADDR_CONTROL, {i[1:0], i[0], 2'b00, i[2:0]});
            rd_reg(ADDR_CONTROL, rv, h);
            check(rv, {i[1:0], i[0], 2'b00, i[2:0]});
            check({vc, mv}, {i[2:0], mv_tab[i]});
            check({mpw, mns}, {i[1:0], ns_tab[i[1:0]]});
            check(sw, i[0]);
        end
        wr_reg(4'h0, ADDR_CONTROL, 8'h21);
        $display("test control done");
    endtask : t_control

    task automatic t_config();
        logic h;
        wr_reg(4'h0, ADDR_CONFIG, 8'hff);
        rd_reg(ADDR_CONFIG, rv, h);
        check(rv, 8'h7f);
        check(pk, 1'b1);
        // other page and unmapped address are refused
        wr_reg(4'h1, ADDR_CONFIG, 8'h00);
        rd_reg(ADDR_CONFIG, rv, h);
        check(rv, 8'h7f);
        rd_reg(8'h98, rv, h);
        check({rv, h}, 9'h000);
        wr_reg(4'h0, ADDR_CONFIG, 8'h00);
        tk(1);
        check(pk, 1'b0);
        $display("test config done");
    endtask : t_config

    task automatic t_backtoback();
        logic h;
        wr_rd_reg(ADDR_CONTROL, 8'h45, rv, h);
        check({h, rv}, 9'h145);
        wr_rd_reg(ADDR_CONFIG, 8'hff, rv, h);
        check({h, rv}, 9'h17f);
        wr_reg(4'h0, ADDR_CONTROL, 8'h21);
        wr_reg(4'h0, ADDR_CONFIG, 8'h00);
        $display("test back to back done");
    endtask : t_backtoback

    task automatic t_clock();
        for (int d = 0; d < 4; d++) begin
            wr_reg(4'h0, ADDR_CONFIG, {1'b0, d[1:0], 4'h0, 1'b1});
            settle();
            check(per, 8'h01 << d);
        end
        // divider ignored on the local oscillator
        wr_reg(4'h0, ADDR_CONFIG, 8'h60);
        settle();
        check(per, 8'h04);
        wr_reg(4'h0, ADDR_CONFIG, 8'h09);
        tk(20);
        check(inv, 1'b1);
        wr_reg(4'h0, ADDR_CONFIG, 8'h01);
        tk(20);
        check(inv, 1'b0);
        $display("test clock done");
    endtask : t_clock

    task automatic t_sleep();
        wr_reg(4'h0, ADDR_CONFIG, 8'h00);
        sleep <= 1'b1;
        tk(2);
        check({en, rail}, 2'b01);
        wr_reg(4'h0, ADDR_CONFIG, 8'h02);
        tk(1);
        check({en, rail}, 2'b00);
        sleep <= 1'b0;
        tk(2);
        check({en, rail}, 2'b10);
        $display("test sleep done");
    endtask : t_sleep

    task automatic t_sync();
        wr_reg(4'h0, ADDR_CONFIG, 8'h11);
        settle();
        check({tseen, sseen}, 2'b00);
        // adc sample clock divider taken as cleared beforehand
        wr_reg(4'h0, ADDR_CONTROL, 8'h29);
        settle();
        check({tseen, sseen}, 2'b11);
        check(stk, 1'b1);
        wr_reg(4'h0, ADDR_CONTROL, 8'h21);
        settle();
        check({tseen, sseen}, 2'b00);
        check(stk, 1'b0);
        $display("test sync done");
    endtask : t_sync

    task automatic t_twocell();
        logic h;
        strap <= 1'b0;
        do_reset();
        tk(2);
        check(en, 1'b0);
        rd_reg(ADDR_CONFIG, rv, h);
        check(rv, 8'h00);
        $display("test two cell done");
    endtask : t_twocell

    // ********************************
    // run control
    // ********************************
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // ceiling well above the fewer than a thousand cycles the run needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict();
        end
    end

    initial begin
        do_reset();
        t_reset();
        t_control();
        t_config();
        t_backtoback();
        t_clock();
        t_sleep();
        t_sync();
        t_twocell();
        print_verdict();
    end
endmodule : conv_regs_tb
